// *** inc/audio_pkg.sv ***
// Function
// [R1] tx port write pushes into 4-deep queue
// [R2] serial mode: width code 8 sends low byte
// [R3] serial mode: width code 0 sends 32 bits
// [R4] audio width code 2: 24-bit samples, low bits
// [R5] audio codes 0,1,3: whole word packed samples
// [R6] clock starts 1+6 cycles after tx write
// [R7] rx port pops oldest of 4-deep queue
// [R8] audio control inert in serial mode
// [R9] bits 29:28 pick audio framing style
// [R10] bit 25 gates left zero-cross interrupt
// [R11] bit 24 gates right zero-cross interrupt
// [R12] mono receive: bit 23 picks channel side
// [R13] bit 17 enables left zero-cross flag
// [R14] zero-cross only from transmitted samples
// [R15] bit 16 enables right zero-cross flag
// [R16] bit 6 selects stereo or mono
// [R17] master drives clock/select pins, follower samples
// [R18] reserved control bits read zero
package audio_pkg;
   localparam logic [7:0]  OFS_SCTL   = 8'h00;
   localparam logic [7:0]  OFS_TX     = 8'h20;
   localparam logic [7:0]  OFS_RX     = 8'h30;
   localparam logic [7:0]  OFS_ACTL   = 8'h60;
   localparam logic [7:0]  OFS_ASTAT  = 8'h64;
   localparam logic [7:0]  OFS_EVT    = 8'h68;
   localparam logic [7:0]  OFS_EMASK  = 8'h6C;
   localparam logic [31:0] ACTL_WMASK = 32'h3383_0170;
   localparam logic [31:0] SCTL_WMASK = 32'h0001_1F00;
   localparam logic [31:0] REG_RESET  = 32'h0000_0000;
   localparam int          SCTL_FBC   = 8;
   localparam int          SCTL_AUDIO = 16;
   localparam int          ST_BUSY    = 0;
   localparam int          ST_RXE     = 8;
   localparam int          ST_RXF     = 9;
   localparam int          ST_TXE     = 16;
   localparam int          ST_TXF     = 17;
   localparam int          EV_W       = 4;
   localparam int          EV_LZC     = 0;
   localparam int          EV_RZC     = 1;
   localparam int          EV_OVR     = 2;
   localparam int          EV_UNIT    = 3;
   localparam int          FIFO_DEPTH = 4;
   localparam logic [2:0]  START_DLY  = 3'h6;
   localparam logic [2:0]  HALF_DIV   = 3'h4;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN  = 3'b100
   } eng_state_t;

   typedef struct packed {
      logic bclk;
      logic ws;
      logic sdi;
   } link_in_t;

   typedef struct packed {
      logic bclk;
      logic bclk_oe_n;
      logic ws;
      logic ws_oe_n;
      logic sdo;
   } link_out_t;

   typedef struct packed {
      logic [1:0] fmt;
      logic       lzc_ie;
      logic       rzc_ie;
      logic       mono_receive_side_select;
      logic       lzc_en;
      logic       rzc_en;
      logic       slave;
      logic       mono;
      logic [1:0] ssz;
   } audio_cfg_t;
endpackage

// *** hw/spi_i2s_data_path.sv ***
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module sample_queue import audio_pkg::*; (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        push,
   input  wire logic [31:0] wdata,
   input  wire logic        pop,
   output logic      [31:0] rdata,
   output logic      [2:0]  cnt,
   output logic             empty,
   output logic             full
);
   logic [31:0] mem [FIFO_DEPTH];
   logic [1:0]  wp_r;
   logic [1:0]  rp_r;
   logic [2:0]  cnt_r;
   wire         do_push = push & ~full;
   wire         do_pop  = pop & ~empty;

   assign rdata = mem[rp_r];
   assign cnt   = cnt_r;
   assign empty = cnt_r == 3'h0;
   assign full  = cnt_r == 3'(FIFO_DEPTH);

   always_ff @(posedge clk_sys) begin
      if (do_push) begin
         mem[wp_r] <= wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= 2'h0;
         rp_r  <= 2'h0;
         cnt_r <= 3'h0;
      end else begin
         wp_r  <= wp_r + {1'b0, do_push};
         rp_r  <= rp_r + {1'b0, do_pop};
         cnt_r <= cnt_r + {2'h0, do_push} - {2'h0, do_pop};
      end
   end
endmodule // sample_queue

module spi_i2s_data_path import audio_pkg::*; (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic        cyc,
   input  wire logic        stb,
   input  wire logic        we,
   input  wire logic [7:0]  adr,
   input  wire logic [3:0]  sel,
   input  wire logic [31:0] dat_w,
   output logic      [31:0] dat_r,
   output logic             ack,
   output logic             irq,
   input  wire link_in_t    link_in,
   output link_out_t        link_out
);
   logic            rst_s1_r, rst_n_r, ack_r, irq_r;
   logic [31:0]     dat_r_r, sctl_r, ctl_r, rd_mux, stat, tx_rdata, rx_rdata;
   logic [EV_W-1:0] ev_r, emask_r;
   link_in_t        lk_s1_r, lk_s2_r;
   eng_state_t      st_r, st_nxt;
   logic [2:0]      dly_r, dly_nxt, div_r, tx_cnt;
   logic [31:0]     tx_sh_r, tx_nxt, rx_sh_r, rx_nxt;
   logic [4:0]      sbit_r, sb_nxt;
   logic [5:0]      wbit_r, wb_nxt, w, u;
   logic            bclk_d_r, bclk_r, ws_r, ch_r, ch_nxt, zc_chk_r, zc_nxt;
   logic [1:0]      sign_r;
   logic            push_rx, unit, ws_fmt, tx_empty, tx_full, rx_empty, rx_full;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n_r);

   // request is answered one cycle later; writes and pops act at the ack edge
   wire        req    = cyc & stb & ~ack_r;
   wire        acc    = cyc & stb & ack_r;
   wire        wr     = acc & we;
   wire        rd     = acc & ~we;
   wire [31:0] bmask  = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   wire [31:0] wdat   = dat_w & bmask;
   wire        h_sctl = adr == OFS_SCTL;
   wire        h_tx   = adr == OFS_TX;
   wire        h_rx   = adr == OFS_RX;
   wire        h_actl = adr == OFS_ACTL;
   wire        h_stat = adr == OFS_ASTAT;
   wire        h_evt  = adr == OFS_EVT;
   wire        h_mask = adr == OFS_EMASK;

   // everything audio-specific is forced to zero while in serial mode
   wire        i2s = sctl_r[SCTL_AUDIO];
   wire [4:0]  fbc = sctl_r[SCTL_FBC +: 5];
   wire audio_cfg_t cfg = i2s ? {ctl_r[29:28], ctl_r[25:23], ctl_r[17:16], ctl_r[8],
                                 ctl_r[6], ctl_r[5:4]} : '0; // R8 R9 R16

   wire         run  = st_r == ST_RUN;
   wire         tx_push = wr & h_tx & ~tx_full; // R1
   wire         rx_pop  = rd & h_rx & ~rx_empty; // R7

   always_comb begin
      if (!i2s) begin
         w = (fbc == 5'h00) ? 6'h20 : {1'b0, fbc}; // R2 R3
         u = w;
      end else begin
         case (cfg.ssz)
            2'h0: w = 6'h08;
            2'h1: w = 6'h10;
            2'h2: w = 6'h18;
            default: w = 6'h20;
         endcase
         u = (cfg.ssz == 2'h2) ? 6'h18 : 6'h20; // R4 R5
      end
   end

   // follower role takes its clock edges from the synchronised pin
   wire slave_m    = cfg.slave; // R17
   wire tgl        = run & ~slave_m & (div_r == HALF_DIV - 3'h1);
   wire rise       = run & (slave_m ? (lk_s2_r.bclk & ~bclk_d_r) : (tgl & ~bclk_r));
   wire fall       = run & (slave_m ? (~lk_s2_r.bclk & bclk_d_r) : (tgl & bclk_r));
   wire samp_end   = {1'b0, sbit_r} == w - 6'h01;
   wire word_end   = wbit_r == u - 6'h01;
   wire first_load = (st_r == ST_WAIT) & (dly_r == START_DLY - 3'h1);
   wire load       = first_load | (fall & word_end & ~tx_empty);
   wire rx_ok      = ~cfg.mono | (ch_r != cfg.mono_receive_side_select); // R12 R16
   wire [31:0] rmask = ~(32'hFFFF_FFFF << w);
   wire [31:0] zmask = ~(32'hFFFF_FFFF >> w);
   wire        zero  = (tx_sh_r & zmask) == 32'h0;
   wire        sgn   = tx_sh_r[31];
   wire lzc = zc_chk_r & ~ch_r & cfg.lzc_en & ((sgn != sign_r[0]) | zero); // R13 R14
   wire rzc = zc_chk_r & ch_r & cfg.rzc_en & ((sgn != sign_r[1]) | zero); // R15 R14
   wire [EV_W-1:0] ev_set = {unit, push_rx & rx_full, rzc, lzc};
   wire [EV_W-1:0] ev_clr = (rd & h_evt) ? dat_r_r[EV_W-1:0] : '0;
   wire [EV_W-1:0] ie     = {2'b11, cfg.rzc_ie, cfg.lzc_ie}; // R10 R11

   sample_queue u_txq (
      .clk_sys (clk_sys),
      .rst_n   (rst_n_r),
      .push    (tx_push),
      .wdata   (wdat),
      .pop     (load),
      .rdata   (tx_rdata),
      .cnt     (tx_cnt),
      .empty   (tx_empty),
      .full    (tx_full)
   );

   sample_queue u_rxq (
      .clk_sys (clk_sys),
      .rst_n   (rst_n_r),
      .push    (push_rx),
      .wdata   (rx_sh_r & rmask),
      .pop     (rx_pop),
      .rdata   (rx_rdata),
      .cnt     (),
      .empty   (rx_empty),
      .full    (rx_full)
   );

   always_comb begin
      st_nxt  = st_r;
      dly_nxt = dly_r;
      tx_nxt  = tx_sh_r;
      rx_nxt  = rx_sh_r;
      sb_nxt  = sbit_r;
      wb_nxt  = wbit_r;
      ch_nxt  = ch_r;
      zc_nxt  = 1'b0;
      push_rx = 1'b0;
      unit    = 1'b0;
      case (st_r)
         ST_IDLE: begin
            dly_nxt = 3'h0;
            if (!tx_empty) begin
               st_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            dly_nxt = dly_r + 3'h1;
            if (first_load) begin // R6
               st_nxt = ST_RUN;
               ch_nxt = 1'b0;
            end
         end
         ST_RUN: begin
            if (rise) begin
               rx_nxt = {rx_sh_r[30:0], lk_s2_r.sdi};
            end
            if (fall) begin
               tx_nxt = tx_sh_r << 1;
               sb_nxt = sbit_r + 5'h01;
               wb_nxt = wbit_r + 6'h01;
               if (samp_end) begin
                  sb_nxt  = 5'h00;
                  ch_nxt  = slave_m ? lk_s2_r.ws : ~ch_r;
                  push_rx = ~i2s | rx_ok; // R7 R12
                  zc_nxt  = i2s & ~word_end; // a following word is checked at its load
               end
               if (word_end) begin
                  wb_nxt = 6'h00;
                  unit   = 1'b1;
                  if (tx_empty) begin
                     st_nxt = ST_IDLE;
                  end
               end
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      if (load) begin
         tx_nxt = tx_rdata << (6'h20 - u); // R2 R3 R4 R5
         sb_nxt = 5'h00;
         wb_nxt = 6'h00;
         zc_nxt = i2s; // R14
      end
   end

   // framing: code 0 marks the channel of the bit that follows, code 1 is high on left, codes 2 and 3 pulse once per frame
   always_comb begin
      case (cfg.fmt) // R9
         2'b00:   ws_fmt = ch_r ^ samp_end;
         2'b01:   ws_fmt = ~ch_r;
         2'b10:   ws_fmt = ch_r & samp_end;
         default: ws_fmt = ~ch_r & (sbit_r == 5'h00);
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_r     <= ST_IDLE;
         dly_r    <= 3'h0;
         tx_sh_r  <= REG_RESET;
         rx_sh_r  <= REG_RESET;
         sbit_r   <= 5'h00;
         wbit_r   <= 6'h00;
         ch_r     <= 1'b0;
         zc_chk_r <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         dly_r    <= dly_nxt;
         tx_sh_r  <= tx_nxt;
         rx_sh_r  <= rx_nxt;
         sbit_r   <= sb_nxt;
         wbit_r   <= wb_nxt;
         ch_r     <= ch_nxt;
         zc_chk_r <= zc_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         lk_s1_r  <= '0;
         lk_s2_r  <= '0;
         bclk_d_r <= 1'b0;
         div_r    <= 3'h0;
         bclk_r   <= 1'b0;
         ws_r     <= 1'b1;
         sign_r   <= 2'b00;
      end else begin
         lk_s1_r  <= link_in;
         lk_s2_r  <= lk_s1_r;
         bclk_d_r <= lk_s2_r.bclk;
         div_r    <= (!run || tgl) ? 3'h0 : div_r + 3'h1;
         bclk_r   <= (run && !slave_m) ? (bclk_r ^ tgl) : 1'b0;
         ws_r     <= i2s ? ws_fmt : ~run; // serial mode: active-low select
         if (zc_chk_r) begin
            sign_r[ch_r] <= sgn;
         end
      end
   end

   assign link_out.bclk      = bclk_r;
   assign link_out.bclk_oe_n = slave_m; // R17
   assign link_out.ws        = ws_r;
   assign link_out.ws_oe_n   = slave_m; // R17
   assign link_out.sdo       = tx_sh_r[31];

   always_comb begin
      stat         = '0;
      stat[ST_BUSY] = st_r != ST_IDLE;
      stat[ST_RXE] = rx_empty;
      stat[ST_RXF] = rx_full;
      stat[ST_TXE] = tx_empty;
      stat[ST_TXF] = tx_full;
      if (h_sctl) begin
         rd_mux = sctl_r;
      end else if (h_rx) begin
         rd_mux = rx_empty ? 32'h0 : rx_rdata; // R7
      end else if (h_actl) begin
         rd_mux = ctl_r;
      end else if (h_stat) begin
         rd_mux = stat;
      end else if (h_evt) begin
         rd_mux = {28'h0, ev_r};
      end else if (h_mask) begin
         rd_mux = {28'h0, emask_r};
      end else begin
         rd_mux = 32'h0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ack_r   <= 1'b0;
         dat_r_r <= REG_RESET;
         sctl_r  <= REG_RESET;
         ctl_r   <= REG_RESET;
         emask_r <= '0;
         ev_r    <= '0;
         irq_r   <= 1'b0;
      end else begin
         ack_r   <= req;
         dat_r_r <= req ? rd_mux : dat_r_r;
         if (wr && h_sctl) begin
            sctl_r <= (sctl_r & ~bmask) | (wdat & SCTL_WMASK);
         end
         if (wr && h_actl) begin
            ctl_r <= (ctl_r & ~bmask) | (wdat & ACTL_WMASK); // R18
         end
         if (wr && h_mask) begin
            emask_r <= wdat[EV_W-1:0];
         end
         // only bits shown by the read are cleared, so a new event survives
         ev_r  <= (ev_r & ~ev_clr) | ev_set;
         irq_r <= |(ev_r & emask_r & ie); // R10 R11
      end
   end

   assign dat_r = dat_r_r;
   assign ack   = ack_r;
   assign irq   = irq_r;

   a_tx_queue_push: assert property ((tx_push && !load) |=> tx_cnt == $past(tx_cnt) + 3'h1) // R1
      else $error("tx write did not add one queue entry");
   a_spi_low_byte: assert property ((load && !i2s && fbc == 5'h08) |=> // R2
      tx_sh_r == {$past(tx_rdata[7:0]), 24'h0}) else $error("8-bit frame not aligned");
   a_spi_full_word: assert property ((load && !i2s && fbc == 5'h00) |=> // R3
      tx_sh_r == $past(tx_rdata)) else $error("32-bit frame not loaded whole");
   a_i2s_24_bit: assert property ((load && i2s && cfg.ssz == 2'h2) |=> // R4
      tx_sh_r == {$past(tx_rdata[23:0]), 8'h0}) else $error("24-bit sample misplaced");
   a_start_delay: assert property ($rose(st_r == ST_WAIT) |-> // R6
      (st_r == ST_WAIT) [*6] ##1 (st_r == ST_RUN)) else $error("clock start delay wrong");
   a_rx_empty_read: assert property ((req && !we && h_rx && rx_empty) |=> // R7
      ack && dat_r == 32'h0) else $error("empty rx read not zero");
   a_serial_inert: assert property ((!i2s && $past(!i2s)) |-> !zc_chk_r && !ev_set[EV_LZC]) // R8
      else $error("audio logic active in serial mode");
   a_left_irq_gate: assert property ((ev_r == 4'h1 && emask_r[EV_LZC]) |=> // R10
      irq == $past(cfg.lzc_ie)) else $error("left zero-cross irq gating wrong");
   a_mono_side: assert property ((push_rx && i2s && cfg.mono) |-> ch_r != cfg.mono_receive_side_select) // R12
      else $error("mono receive took wrong channel");
   a_left_zc_cause: assert property ($rose(ev_r[EV_LZC]) |-> // R13
      $past(cfg.lzc_en && zc_chk_r && !ch_r)) else $error("left flag without cause");
   a_ctl_reserved: assert property ((wr && h_actl) |=> (ctl_r & ~ACTL_WMASK) == 32'h0) // R18
      else $error("reserved control bits set");
endmodule // spi_i2s_data_path

// *** verif/codec_model.sv ***
`timescale 1ns/1ps
module codec_model import audio_pkg::*; (
   input  wire logic        clk_sys,
   input  wire logic        clr,
   input  wire link_out_t   link_out,
   output link_in_t         link_in,
   output logic      [31:0] cap,
   output logic      [7:0]  nbits
);
   logic [7:0] pat = 8'hC3;
   logic [2:0] pos_r = 3'h0;
   logic       bclk_q = 1'b0;

   // the pins are seen only through our own sampling, as a real codec would see them
   always @(posedge clk_sys) begin
      bclk_q <= link_out.bclk;
      if (clr) begin
         cap <= 32'h0;
         nbits <= 8'h0;
      end else if (link_out.bclk && !bclk_q) begin
         cap <= {cap[30:0], link_out.sdo};
         nbits <= nbits + 8'h1;
      end
      if (link_out.ws) begin
         pos_r <= 3'h0;
      end else if (!link_out.bclk && bclk_q) begin
         pos_r <= pos_r + 3'h1;
      end
   end

   // master role only: clock and select pins are left to the device
   assign link_in = {1'b0, 1'b0, pat[3'h7 - pos_r]};
endmodule // codec_model

// *** verif/spi_i2s_data_path_and_audio_control_tb.sv ***
`timescale 1ns/1ps
module spi_i2s_data_path_and_audio_control_tb import audio_pkg::*;;
   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic        cyc     = 1'b0;
   logic        stb     = 1'b0;
   logic        we      = 1'b0;
   logic [7:0]  adr     = 8'h00;
   logic [3:0]  sel     = 4'h0;
   logic [31:0] dat_w   = 32'h0;
   logic        clr     = 1'b0;
   logic [31:0] dat_r;
   logic        ack;
   logic        irq;
   logic [31:0] cap;
   logic [7:0]  nbits;
   logic [31:0] q;
   link_in_t    link_in;
   link_out_t   link_out;
   int          err_count = 0;
   int          checks = 0;

   always #4 clk_sys = ~clk_sys;

   spi_i2s_data_path i_spi_i2s_data_path (.clk_sys(clk_sys), .reset_n(reset_n), .cyc(cyc),
      .stb(stb), .we(we), .adr(adr), .sel(sel), .dat_w(dat_w), .dat_r(dat_r), .ack(ack),
      .irq(irq), .link_in(link_in), .link_out(link_out));

   codec_model i_codec_model (.clk_sys(clk_sys), .clr(clr), .link_out(link_out),
      .link_in(link_in), .cap(cap), .nbits(nbits));

   task end_sim;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // no cycle limit here: a bus that never answers is caught by the watchdog
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dat_w <= d;
      do begin
         @(posedge clk_sys);
      end while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_sys);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(q, exp);
   endtask

   task clr_model;
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
   endtask

   // polls status; bounded so a stuck engine shows as a mismatch
   task wait_idle;
      int n;
      n = 0;
      do begin
         xfer(1'b0, OFS_ASTAT, 32'h0);
         n++;
      end while ((q[ST_BUSY] !== 1'b0 || q[ST_TXE] !== 1'b1) && n < 300);
      chk({31'h0, q[ST_BUSY]}, 32'h0);
   endtask

   initial begin
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(OFS_ACTL, REG_RESET);
      rd(OFS_RX, 32'h0);
      rd(8'h40, 32'h0);
      wr(OFS_ACTL, 32'hFFFF_FFFF);
      rd(OFS_ACTL, ACTL_WMASK);
      wr(OFS_ACTL, 32'h0003_0020);
      wr(OFS_SCTL, 32'h0000_0800);
      clr_model;
      wr(OFS_TX, 32'hA5C3_5A96);
      repeat (6) begin
         @(posedge clk_sys);
         chk({31'h0, link_out.bclk}, 32'h0);
      end
      wait_idle;
      chk({24'h0, nbits}, 32'h8);
      chk({24'h0, cap[7:0]}, 32'h96);
      chk({30'h0, link_out.bclk_oe_n, link_out.ws_oe_n}, 32'h0);
      wr(OFS_SCTL, 32'h0);
      clr_model;
      wr(OFS_TX, 32'h5A96_A5C3);
      wait_idle;
      chk({24'h0, nbits}, 32'h20);
      chk(cap, 32'h5A96_A5C3);
      rd(OFS_RX, 32'h0000_00C3);
      rd(OFS_RX, 32'hC3C3_C3C3);
      xfer(1'b0, OFS_EVT, 32'h0);
      wr(OFS_SCTL, 32'h0000_0800);
      wr(OFS_EMASK, 32'h8);
      clr_model;
      // six words against a four-deep queue: the last one is refused
      for (int i = 1; i < 7; i++) begin
         wr(OFS_TX, 32'h11 * i);
      end
      wait_idle;
      chk({24'h0, nbits}, 32'h28);
      chk({24'h0, cap[7:0]}, 32'h55);
      chk({31'h0, irq}, 32'h1);
      rd(OFS_EVT, 32'h0000_000C);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         rd(OFS_RX, 32'h0000_00C3);
      end
      rd(OFS_RX, 32'h0);
      wr(OFS_ACTL, 32'h0203_0020);
      wr(OFS_EMASK, 32'h3);
      wr(OFS_SCTL, 32'h0001_0000);
      xfer(1'b0, OFS_EVT, 32'h0);
      repeat (2) wr(OFS_TX, 32'h0);
      wait_idle;
      chk({31'h0, irq}, 32'h1);
      xfer(1'b0, OFS_EVT, 32'h0);
      chk(q & 32'h3, 32'h3);
      // mono, left side kept: of two samples only one reaches the rx queue
      wr(OFS_ACTL, 32'h0183_0060);
      repeat (2) wr(OFS_TX, 32'h0);
      wait_idle;
      chk({31'h0, q[ST_RXF]}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_ACTL, 32'h0003_0020);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b0, OFS_EVT, 32'h0);
      chk(q & 32'h3, 32'h3);
      // 16-bit samples, two per word, msb-justified framing: ws high on left
      wr(OFS_ACTL, 32'h1000_0010);
      clr_model;
      wr(OFS_TX, 32'h9C35_0F6A);
      wait_idle;
      chk({24'h0, nbits}, 32'h20);
      chk(cap, 32'h9C35_0F6A);
      chk({31'h0, link_out.ws}, 32'h1);
      wr(OFS_ACTL, 32'h0003_0120);
      repeat (2) @(posedge clk_sys);
      chk({30'h0, link_out.bclk_oe_n, link_out.ws_oe_n}, 32'h3);
      end_sim;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      end_sim;
   end
endmodule // spi_i2s_data_path_and_audio_control_tb
